// ### core/wdt_pkg.sv
// Shared constants and types of the watchdog timer.
package wdt_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] WDT_CTRL_INDEX = 8'h2a;
	localparam logic [7:0] WDT_CFG_INDEX  = 8'h2b;
	localparam int         WDT_ADDR_W     = 8;

	// Control register layout and reset value.
	localparam int         WDT_ACT_BIT    = 7;
	localparam int         WDT_TOP_BIT    = 6;
	localparam int         WDT_COUNT_W    = 7;
	localparam logic [7:0] WDT_CTRL_RESET = 8'h7f;
	localparam logic [6:0] WDT_ROLL_FROM  = 7'h40;
	localparam logic [6:0] WDT_COUNT_ONE  = 7'h01;

	// Configuration register layout and reset value.
	localparam int         WDT_TB_LSB     = 0;
	localparam int         WDT_TB_W       = 2;
	localparam int         WDT_OIE_BIT    = 2;
	localparam logic [2:0] WDT_CFG_RESET  = 3'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int WDT_CLK_MHZ        = 50;
	localparam int WDT_TICK_OSC       = 16384;
	localparam int WDT_RESET_PULSE_NS = 30000;
	// A least duration, so the cycle count rounds up.
	localparam int WDT_RESET_CYCLES   = (WDT_RESET_PULSE_NS * WDT_CLK_MHZ + 999) / 1000;
	localparam int WDT_PULSE_W        = 12;

	// Real-time timebase periods in milliseconds and in clock cycles.
	localparam int WDT_TB0_MS     = 2;
	localparam int WDT_TB1_MS     = 4;
	localparam int WDT_TB2_MS     = 10;
	localparam int WDT_TB3_MS     = 25;
	localparam int WDT_TB0_CYCLES = WDT_TB0_MS * WDT_CLK_MHZ * 1000;
	localparam int WDT_TB1_CYCLES = WDT_TB1_MS * WDT_CLK_MHZ * 1000;
	localparam int WDT_TB2_CYCLES = WDT_TB2_MS * WDT_CLK_MHZ * 1000;
	localparam int WDT_TB3_CYCLES = WDT_TB3_MS * WDT_CLK_MHZ * 1000;

	// ----------------------------------------------------------------
	// Halt handling states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WDT_RUN     = 2'b00,
		WDT_ONEMORE = 2'b01,
		WDT_FROZEN  = 2'b10
	} wdt_halt_state_type;

endpackage

// ### core/wdt_prescaler.sv
// Shared prescaler giving the watchdog step tick and the real-time timebase tick.
module wdt_prescaler #(
	parameter int TICK_CYCLES = 16384,
	parameter int TB0_CYCLES  = 100000,
	parameter int TB1_CYCLES  = 200000,
	parameter int TB2_CYCLES  = 500000,
	parameter int TB3_CYCLES  = 1250000
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] tbSelect,
	output logic            wdTick,
	output logic            rtcTick
);

	localparam int WD_W  = $clog2(TICK_CYCLES);
	localparam int RTC_W = 21;

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	generate
		if (TICK_CYCLES < 2 || TB0_CYCLES < 2 || TB3_CYCLES >= (1 << RTC_W)) begin : gBadParam
			$error("wdt_prescaler: period parameter out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	logic [WD_W-1:0]  wdCount_reg;
	logic [RTC_W-1:0] rtcCount_reg;
	logic [RTC_W-1:0] rtcLast;
	logic             wdWrap;
	logic             rtcWrap;

	// Timebase period picked by the select code, as the last count value.
	assign rtcLast = (tbSelect == 2'h0) ? RTC_W'(TB0_CYCLES - 1) :
	                 (tbSelect == 2'h1) ? RTC_W'(TB1_CYCLES - 1) :
	                 (tbSelect == 2'h2) ? RTC_W'(TB2_CYCLES - 1) : RTC_W'(TB3_CYCLES - 1);
	assign wdWrap  = (wdCount_reg == WD_W'(TICK_CYCLES - 1));
	assign rtcWrap = (rtcCount_reg >= rtcLast);

	// The timebase wrap also restarts the watchdog stage, since both share one chain.
	// This is why the exact timeout depends on the selected timebase.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wdCount_reg  <= '0;
			rtcCount_reg <= '0;
			wdTick       <= 1'b0;
			rtcTick      <= 1'b0;
		end else begin
			wdCount_reg  <= (wdWrap || rtcWrap) ? '0 : wdCount_reg + WD_W'(1);
			rtcCount_reg <= rtcWrap ? '0 : rtcCount_reg + RTC_W'(1);
			wdTick       <= wdWrap;
			rtcTick      <= rtcWrap;
		end
	end

endmodule

// ### core/wdt_reset_pulse.sv
// Reset pulse stretcher that drives the chip reset low for a fixed time.
module wdt_reset_pulse #(
	parameter int PULSE_CYCLES = 1500
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic trigger,
	output logic      resetOut_n,
	output logic      busy
);

	localparam int W = wdt_pkg::WDT_PULSE_W;

	generate
		if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << W)) begin : gBadParam
			$error("wdt_reset_pulse: pulse length out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pulse counter
	// ----------------------------------------------------------------
	logic [W-1:0] left_reg;
	logic [W-1:0] left_next;

	// A trigger during a running pulse is absorbed; the pulse is never cut short.
	assign left_next = (left_reg != '0) ? left_reg - W'(1) :
	                   trigger          ? W'(PULSE_CYCLES) : '0;
	assign busy      = (left_reg != '0);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			left_reg   <= '0;
			resetOut_n <= 1'b1;
		end else begin
			left_reg   <= left_next;
			resetOut_n <= (left_next == '0);
		end
	end

endmodule

// ### core/wdt_core.sv
// Watchdog timer with a Wishbone register slave, halt handling and reset pulse.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.

module wdt_core #(
	parameter int TICK_CYCLES = wdt_pkg::WDT_TICK_OSC,
	parameter int TB0_CYCLES  = wdt_pkg::WDT_TB0_CYCLES,
	parameter int TB1_CYCLES  = wdt_pkg::WDT_TB1_CYCLES,
	parameter int TB2_CYCLES  = wdt_pkg::WDT_TB2_CYCLES,
	parameter int TB3_CYCLES  = wdt_pkg::WDT_TB3_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        haltExec,
	input  wire logic        wakeEvent,
	input  wire logic        hwWatchdogOpt,
	input  wire logic        haltResetOpt,
	output logic             resetOut_n,
	output logic             resetBusy,
	output logic             rtcTick
);

	localparam int CW = wdt_pkg::WDT_COUNT_W;

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	generate
		if (wdt_pkg::WDT_ADDR_W != 8) begin : gBadAddr
			$error("wdt_core: address width must be 8");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [CW-1:0]                 count_reg;
	logic [CW-1:0]                 count_next;
	logic                          active_reg;
	logic                          active_next;
	logic [1:0]                    tbSel_reg;
	logic                          oscIntEn_reg;
	logic                          hwOpt_reg;
	logic                          haltOpt_reg;
	logic                          optLoaded_reg;
	logic                          ack_reg;
	logic [31:0]                   rdata_reg;
	wdt_pkg::wdt_halt_state_type   halt_reg;
	wdt_pkg::wdt_halt_state_type   halt_next;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire        busReq   = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire [5:0]  regIndex = wb_adr_i[7:2];
	wire        ctrlHit  = (regIndex == wdt_pkg::WDT_CTRL_INDEX[5:0]);
	wire        cfgHit   = (regIndex == wdt_pkg::WDT_CFG_INDEX[5:0]);
	wire        ctrlWrite = busReq & wb_we_i & wb_sel_i[0] & ctrlHit;
	wire        cfgWrite  = busReq & wb_we_i & wb_sel_i[0] & cfgHit;
	wire        wrAct     = wb_dat_i[wdt_pkg::WDT_ACT_BIT];
	wire        wrTop     = wb_dat_i[wdt_pkg::WDT_TOP_BIT];
	wire [31:0] ctrlView  = {24'h000000, active_reg, count_reg};
	wire [31:0] cfgView   = {29'h00000000, oscIntEn_reg, tbSel_reg};

	// Every register is one byte wide and lives in the low lane of its word.
	// The two low address bits are ignored, so a master may use any byte address
	// inside a word and still reach the register.
	// A byte select of zero on lane 0 turns a write into a plain acknowledge.
	// The acknowledge itself blocks a second take while it stands.
	// Unmapped addresses are acknowledged and read as zero, so no bus cycle hangs.
	wire [31:0] rdataNext = ctrlHit ? ctrlView : cfgHit ? cfgView : 32'h00000000;

	// ----------------------------------------------------------------
	// Prescaler and reset pulse
	// ----------------------------------------------------------------
	logic wdTick;
	logic resetTrig;

	// The prescaler is never restarted by a control register write. Software therefore
	// cannot know where in the current step it lands, and the timeout of a
	// freshly loaded count varies by up to one step.
	// That spread is the price of sharing one chain with the timebase.
	// Shared timebase prescaler.
	wdt_prescaler #(
		.TICK_CYCLES (TICK_CYCLES),
		.TB0_CYCLES  (TB0_CYCLES),
		.TB1_CYCLES  (TB1_CYCLES),
		.TB2_CYCLES  (TB2_CYCLES),
		.TB3_CYCLES  (TB3_CYCLES)
	) uPrescaler (
		.clk      (clk),
		.rst_n    (rst_n),
		.tbSelect (tbSel_reg),
		.wdTick   (wdTick),
		.rtcTick  (rtcTick)
	);

	// The stretcher absorbs new triggers while a pulse runs, so several causes
	// in a row still give a single clean pulse on the reset pin.
	// Fixed-length reset pulse.
	wdt_reset_pulse #(
		.PULSE_CYCLES (wdt_pkg::WDT_RESET_CYCLES)
	) uResetPulse (
		.clk        (clk),
		.rst_n      (rst_n),
		.trigger    (resetTrig),
		.resetOut_n (resetOut_n),
		.busy       (resetBusy)
	);

	// ----------------------------------------------------------------
	// Watchdog logic
	// ----------------------------------------------------------------
	// A step is one decrement of the seven-bit count.
	// The count keeps moving while the watchdog is inactive, so a later activation
	// sees a live value and not a frozen one.
	// The top count bit doubles as the armed flag: while it is set no rollover
	// can happen, and its fall from 40h is what fires the reset.
	// A write that lands in the same cycle as a step wins, and the step is lost.
	// That costs at most one step of timeout, which software cannot see anyway.
	// Hardware mode forces activity.
	wire effActive = active_reg | hwOpt_reg;
	// Steps continue regardless of activation; only halt freezes them.
	wire stepEn    = wdTick & (halt_reg != wdt_pkg::WDT_FROZEN);

	// Timeout set by the loaded steps.
	// A write loads the count and may set the activation bit; the prescaler phase stays untouched.
	assign count_next  = ctrlWrite ? wb_dat_i[CW-1:0] :
	                     stepEn    ? count_reg - wdt_pkg::WDT_COUNT_ONE : count_reg;
	assign active_next = active_reg | (ctrlWrite & wrAct);

	wire rollReset = effActive & stepEn & ~ctrlWrite & (count_reg == wdt_pkg::WDT_ROLL_FROM);
	// Software reset by clearing the top bit.
	wire swReset   = ctrlWrite & (active_next | hwOpt_reg) & ~wrTop;
	wire haltReset = haltExec & effActive & ~oscIntEn_reg & haltOpt_reg;
	assign resetTrig = rollReset | swReset | haltReset;

	// Halt handling keeps its own small state, apart from the count.
	// RUN lets steps through, ONEMORE lets exactly one more step through and
	// FROZEN blocks them until a wake event arrives.
	// The delay that a real part spends before it restarts after a wake is not
	// modelled; counting resumes in the next cycle.
	// Halt without reset: one more step then freeze, or freeze at once in active-halt.
	always_comb begin
		halt_next = halt_reg;
		unique case (halt_reg)
			wdt_pkg::WDT_RUN: begin
				if (haltExec && !haltReset) begin
					halt_next = oscIntEn_reg ? wdt_pkg::WDT_FROZEN : wdt_pkg::WDT_ONEMORE;
				end
			end
			wdt_pkg::WDT_ONEMORE: begin
				if (stepEn) begin
					halt_next = wdt_pkg::WDT_FROZEN;
				end
			end
			wdt_pkg::WDT_FROZEN: begin
				halt_next = wdt_pkg::WDT_FROZEN;
			end
			default: begin
				halt_next = wdt_pkg::WDT_RUN;
			end
		endcase
		if (wakeEvent) begin
			halt_next = wdt_pkg::WDT_RUN;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg  <= wdt_pkg::WDT_CTRL_RESET[CW-1:0];
			active_reg <= wdt_pkg::WDT_CTRL_RESET[wdt_pkg::WDT_ACT_BIT];
			halt_reg   <= wdt_pkg::WDT_RUN;
		end else begin
			count_reg  <= count_next;
			active_reg <= active_next;
			halt_reg   <= halt_next;
		end
	end

	// Configuration register for the timebase select and oscillator interrupt enable.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tbSel_reg    <= wdt_pkg::WDT_CFG_RESET[1:0];
			oscIntEn_reg <= wdt_pkg::WDT_CFG_RESET[wdt_pkg::WDT_OIE_BIT];
		end else if (cfgWrite) begin
			tbSel_reg    <= wb_dat_i[wdt_pkg::WDT_TB_LSB +: wdt_pkg::WDT_TB_W];
			oscIntEn_reg <= wb_dat_i[wdt_pkg::WDT_OIE_BIT];
		end
	end

	// The straps stand for option-byte bits, which cannot change while running.
	// Catching them once keeps a glitch on the pins from flipping the mode later.
	// Option straps caught once after release.
	// Catching them late costs one cycle of hardware mode but keeps reset values constant.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hwOpt_reg     <= 1'b0;
			haltOpt_reg   <= 1'b0;
			optLoaded_reg <= 1'b0;
		end else if (!optLoaded_reg) begin
			hwOpt_reg     <= hwWatchdogOpt;
			haltOpt_reg   <= haltResetOpt;
			optLoaded_reg <= 1'b1;
		end
	end

	// Read data come from a register, so they are stable for the whole ack cycle.
	// The value returned is the count as it stood in the cycle of the request.
	// Read data captured with the request.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg   <= busReq;
			rdata_reg <= busReq ? rdataNext : rdata_reg;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [wdt_pkg::WDT_PULSE_W-1:0] lowRun_reg;

	// Length of the current low phase of the reset output, read only by a check.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lowRun_reg <= '0;
		end else begin
			lowRun_reg <= resetOut_n ? '0 : lowRun_reg + wdt_pkg::WDT_PULSE_W'(1);
		end
	end

	// All checks below share the one clock and are silent while reset is held.
	// They look only at what this block drives, never at bus inputs alone.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	step_by_one_a: assert property (stepEn && !ctrlWrite |=> count_reg == $past(count_reg) - 7'h01)
		else $error("count did not step by one");
	rollover_reset_a: assert property (rollReset |=> ##1 !resetOut_n)
		else $error("rollover did not pull reset low");
	free_running_a: assert property (!effActive && wdTick && halt_reg == wdt_pkg::WDT_RUN && !ctrlWrite
		|=> count_reg != $past(count_reg))
		else $error("inactive counter stopped");
	act_sticky_a: assert property (active_reg |=> active_reg)
		else $error("activation cleared without reset");
	sw_reset_a: assert property (ctrlWrite && wrAct && !wrTop |=> ##1 !resetOut_n)
		else $error("software reset not issued");
	halt_reset_a: assert property (haltExec && effActive && !oscIntEn_reg && haltOpt_reg
		|=> resetBusy)
		else $error("halt did not start reset");
	freeze_hold_a: assert property (halt_reg == wdt_pkg::WDT_FROZEN && !ctrlWrite |=> $stable(count_reg))
		else $error("frozen counter moved");
	pulse_len_a: assert property ($rose(resetOut_n) |-> lowRun_reg == wdt_pkg::WDT_PULSE_W'(wdt_pkg::WDT_RESET_CYCLES))
		else $error("reset pulse length wrong");
	ctrl_read_a: assert property (busReq && !wb_we_i && ctrlHit |=> wb_ack_o && wb_dat_o[7:0] == $past(ctrlView[7:0]))
		else $error("control read data wrong");
	// Hardware mode keeps the watchdog active.
	hw_active_a: assert property (hwOpt_reg && stepEn && !ctrlWrite
		&& count_reg == wdt_pkg::WDT_ROLL_FROM |=> resetBusy)
		else $error("hardware mode not active");
	write_load_a: assert property (ctrlWrite |=> count_reg == $past(wb_dat_i[6:0]))
		else $error("write did not load count");
	// Bus answers one cycle after the taking edge.
	ack_next_a: assert property (busReq |=> wb_ack_o)
		else $error("request not acknowledged");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held too long");
	ack_quiet_a: assert property (!busReq |=> !wb_ack_o)
		else $error("acknowledge without request");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	// Activation only rises by a write.
	act_by_write_a: assert property (!active_reg && !(ctrlWrite && wrAct) |=> !active_reg)
		else $error("activation set without write");
	// A trigger into an idle stretcher starts the pulse.
	pulse_start_a: assert property (resetTrig && !resetBusy |=> resetBusy && !resetOut_n)
		else $error("reset pulse did not start");
	halt_freeze_a: assert property (haltExec && !haltReset && oscIntEn_reg && !wakeEvent
		&& halt_reg == wdt_pkg::WDT_RUN |=> halt_reg == wdt_pkg::WDT_FROZEN)
		else $error("active halt did not freeze");
	// Plain halt takes one more step and then freezes.
	one_more_a: assert property (halt_reg == wdt_pkg::WDT_ONEMORE && stepEn && !wakeEvent
		|=> halt_reg == wdt_pkg::WDT_FROZEN)
		else $error("halt did not freeze after one step");
	wake_run_a: assert property (wakeEvent |=> halt_reg == wdt_pkg::WDT_RUN)
		else $error("wake did not resume counting");
	cfg_read_a: assert property (busReq && !wb_we_i && cfgHit |=> wb_dat_o[2:0] == $past(cfgView[2:0]))
		else $error("config read data wrong");
	// Timebase tick is one cycle wide.
	rtc_single_a: assert property (rtcTick |=> !rtcTick)
		else $error("timebase tick too wide");

endmodule

// ### tb/wdt_core_tb.sv
// Self-checking testbench of the watchdog core, driven over its Wishbone register port.
module wdt_core_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Settings and signals
	// ----------------------------------------------------------------
	// Short prescaler and timebase counts keep the run small; expectations follow them.
	localparam int         TICK       = 16;
	localparam int         TB [4]     = '{200, 400, 1000, 2500};
	localparam logic [7:0] CTRL_ADR   = wdt_pkg::WDT_CTRL_INDEX << 2;
	localparam logic [7:0] CFG_ADR    = wdt_pkg::WDT_CFG_INDEX << 2;

	logic        clk;
	logic        rst_n;
	logic        wbCyc;
	logic        wbStb;
	logic        wbWe;
	logic [7:0]  wbAdr;
	logic [3:0]  wbSel;
	logic [31:0] wbDatIn;
	logic [31:0] wbDatOut;
	logic        wbAck;
	logic        haltExec;
	logic        wakeEvent;
	logic        hwOpt;
	logic        haltOpt;
	logic        resetOut_n;
	logic        resetBusy;
	logic        rtcTick;
	logic        sawReset;
	logic [7:0]  q;
	logic [7:0]  q1;
	int          fails;
	int          samplesChecked;
	int          lowRun;
	int          lastPulse;
	int          n;

	wdt_core #(.TICK_CYCLES(TICK), .TB0_CYCLES(TB[0]), .TB1_CYCLES(TB[1]), .TB2_CYCLES(TB[2]),
		.TB3_CYCLES(TB[3])) uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatIn), .wb_dat_o(wbDatOut),
		.wb_ack_o(wbAck), .haltExec(haltExec), .wakeEvent(wakeEvent), .hwWatchdogOpt(hwOpt),
		.haltResetOpt(haltOpt), .resetOut_n(resetOut_n), .resetBusy(resetBusy), .rtcTick(rtcTick));

	// The 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Measures every low run of the reset pin, so the pulse length is exact even if a task starts late.
	always @(posedge clk) begin
		if (resetOut_n === 1'b0) begin
			lowRun <= lowRun + 1;
			sawReset <= 1'b1;
		end else begin
			if (lowRun != 0) lastPulse <= lowRun;
			lowRun <= 0;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic checkRange(input string what, input int lo, input int hi, input logic [31:0] got);
		samplesChecked++;
		if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
			fails++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	// One classic cycle; it is entered just after a rising edge and holds until ack is sampled.
	task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [7:0] d, output logic [7:0] rd);
		int k;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= 4'h1;
		wbDatIn <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wbAck !== 1'b1 && k < 20);
		rd = wbDatOut[7:0];
		if (wbAck !== 1'b1) begin
			fails++;
			$display("MISMATCH bus_ack expected 1 seen %b", wbAck);
		end
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wbWrite(input logic [7:0] adr, input logic [7:0] d);
		logic [7:0] unused;
		wbXfer(1'b1, adr, d, unused);
	endtask

	task automatic waitLow(output int k);
		k = 0;
		while (resetOut_n !== 1'b0 && k < 400) begin
			@(posedge clk);
			k++;
		end
	endtask

	// Waits out a running pulse; one more edge lets the pulse monitor settle.
	task automatic waitIdle();
		int k;
		k = 0;
		while (resetOut_n !== 1'b1 && k < 2000) begin
			@(posedge clk);
			k++;
		end
		@(posedge clk);
	endtask

	task automatic waitTick(output int k);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rtcTick !== 1'b1 && k < 3000);
	endtask

	// One-cycle strobe on the halt input (wake low) or the wake input (wake high).
	task automatic pulse(input logic wake);
		if (wake) begin
			wakeEvent <= 1'b1;
		end else begin
			haltExec <= 1'b1;
		end
		@(posedge clk);
		wakeEvent <= 1'b0;
		haltExec <= 1'b0;
	endtask

	// The straps stay stable from reset through the capture edge after release.
	task automatic doReset(input logic hw, input logic hr);
		waitIdle();
		rst_n <= 1'b0;
		hwOpt <= hw;
		haltOpt <= hr;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		sawReset <= 1'b0;
		@(posedge clk);
	endtask

	task automatic report_and_stop();
		$display("fails %0d samples_checked %0d", fails, samplesChecked);
		if (fails == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Bounds the whole run in case the design never answers.
	initial begin
		#2000000;
		fails++;
		$display("MISMATCH watchdog expected finish seen timeout");
		report_and_stop();
	end

	initial begin
		{rst_n, wbCyc, wbStb, wbWe, haltExec, wakeEvent, hwOpt, haltOpt, sawReset} = '0;
		wbAdr = 8'h00;
		wbSel = 4'h0;
		wbDatIn = 32'h0;
		{fails, samplesChecked, lowRun, lastPulse} = '0;
		@(posedge clk);
		doReset(1'b0, 1'b0);
		wbXfer(1'b0, CTRL_ADR, 8'h00, q);
		check("ctrl_reset", 8'h7f, q);
		wbXfer(1'b0, CFG_ADR, 8'h00, q);
		check("cfg_reset", 8'h00, q);
		wbXfer(1'b0, 8'h00, 8'h00, q);
		check("unmapped_read", 8'h00, q);
		repeat (1120) @(posedge clk);
		wbXfer(1'b0, CTRL_ADR, 8'h00, q);
		checkRange("free_count", 8'h30, 8'h3f, q);
		check("no_reset_inactive", 1'b0, sawReset);
		// Step rate, allowing one timebase restart in the window.
		wbXfer(1'b0, CTRL_ADR, 8'h00, q1);
		repeat (160) @(posedge clk);
		wbXfer(1'b0, CTRL_ADR, 8'h00, q);
		checkRange("step_rate", 8, 11, q1 - q);
		wbWrite(CTRL_ADR, 8'hc5);
		wbXfer(1'b0, CTRL_ADR, 8'h00, q);
		check("act_set", 1'b1, q[7]);
		checkRange("loaded_count", 8'h43, 8'h45, q[6:0]);
		wbWrite(CTRL_ADR, 8'h45);
		wbXfer(1'b0, CTRL_ADR, 8'h00, q);
		check("act_sticky", 1'b1, q[7]);
		wbWrite(CTRL_ADR, 8'h80);
		waitLow(n);
		checkRange("sw_reset_delay", 0, 2, n);
		check("busy_in_pulse", 1'b1, resetBusy);
		waitIdle();
		check("pulse_len", wdt_pkg::WDT_RESET_CYCLES, lastPulse);
		// Timeout from the loaded low bits, with unknown prescaler phase.
		foreach (TB[i]) begin
			if (i < 2) begin
				doReset(1'b0, 1'b0);
				wbWrite(CTRL_ADR, 8'hc0 | 8'(i * 5));
				waitLow(n);
				checkRange("timeout_len", i * 5 * TICK - 4, (i * 5 + 2) * TICK + 4, n);
			end
		end
		// Hardware mode ignores the activation bit.
		doReset(1'b1, 1'b0);
		wbWrite(CTRL_ADR, 8'h41);
		waitLow(n);
		checkRange("hw_mode_timeout", TICK - 4, 3 * TICK + 4, n);
		// Halt with the option set and the oscillator enable clear.
		doReset(1'b0, 1'b1);
		wbWrite(CTRL_ADR, 8'hff);
		pulse(1'b0);
		waitLow(n);
		checkRange("halt_reset", 0, 3, n);
		// Halt cases that freeze the counter instead.
		for (int k = 0; k < 2; k++) begin
			doReset(1'b0, k == 0);
			wbWrite(CTRL_ADR, 8'hff);
			if (k == 0) wbWrite(CFG_ADR, 8'h04);
			pulse(1'b0);
			repeat (40) @(posedge clk);
			wbXfer(1'b0, CTRL_ADR, 8'h00, q1);
			repeat (100) @(posedge clk);
			wbXfer(1'b0, CTRL_ADR, 8'h00, q);
			check("frozen_count", q1, q);
			check("no_halt_reset", 1'b0, sawReset);
			pulse(1'b1);
			repeat (100) @(posedge clk);
			wbXfer(1'b0, CTRL_ADR, 8'h00, q);
			checkRange("resumed_steps", 4, 7, q1 - q);
		end
		// Every timebase code, measured on a clean period.
		doReset(1'b0, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wbWrite(CFG_ADR, 8'(c));
			waitTick(n);
			waitTick(n);
			check("tb_period", TB[c], n);
		end
		report_and_stop();
	end
endmodule
